// *** tcr_pkg.sv ***
package tcr_pkg;
	// Register byte addresses on the internal I/O bus
	localparam logic [5:0] TCR_ADDR_FLAGS = 6'h0b;
	localparam logic [5:0] TCR_ADDR_MASK = 6'h0c;
	localparam logic [5:0] TCR_ADDR_FORCE = 6'h22;
	localparam logic [5:0] TCR_ADDR_CAP_L = 6'h24;
	localparam logic [5:0] TCR_ADDR_CAP_H = 6'h25;
	localparam logic [5:0] TCR_ADDR_CMPB_L = 6'h28;
	localparam logic [5:0] TCR_ADDR_CMPB_H = 6'h29;
	localparam logic [5:0] TCR_ADDR_CMPA_L = 6'h2a;
	localparam logic [5:0] TCR_ADDR_CMPA_H = 6'h2b;
	localparam logic [5:0] TCR_ADDR_CNT_L = 6'h2c;
	localparam logic [5:0] TCR_ADDR_CNT_H = 6'h2d;
	// Bit positions in the mask, flag and force registers
	localparam int TCR_BIT_CAP = 5;
	localparam int TCR_BIT_CMPB = 2;
	localparam int TCR_BIT_CMPA = 1;
	localparam int TCR_BIT_OVF = 0;
	localparam int TCR_BIT_FORCE_A = 7;
	localparam int TCR_BIT_FORCE_B = 6;
	// Internal event index order
	localparam int TCR_EV_OVF = 0;
	localparam int TCR_EV_CMPA = 1;
	localparam int TCR_EV_CMPB = 2;
	localparam int TCR_EV_CAP = 3;
	// Reset values and fixed tops
	localparam logic [15:0] TCR_RST16 = 16'h0000;
	localparam logic [7:0] TCR_RST8 = 8'h00;
	localparam logic [3:0] TCR_RST4 = 4'h0;
	localparam logic [15:0] TCR_MAX = 16'hffff;
	localparam logic [15:0] TCR_TOP8 = 16'h00ff;
	localparam logic [15:0] TCR_TOP9 = 16'h01ff;
	localparam logic [15:0] TCR_TOP10 = 16'h03ff;
	// Compare output mode codes
	localparam logic [1:0] TCR_COM_OFF = 2'h0;
	localparam logic [1:0] TCR_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TCR_COM_CLEAR = 2'h2;
	localparam logic [1:0] TCR_COM_SET = 2'h3;
endpackage

// *** tcr_compare_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcr_compare_unit
	import tcr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Events
	input wire logic match,
	input wire logic force_hit,
	input wire logic wrap,
	// Configuration
	input wire logic pwm_mode,
	input wire logic [1:0] compare_output_mode,
	// Pin
	output logic wave_out
);
	typedef struct packed {
		logic wave;
	} tcr_cu_s;

	tcr_cu_s st_q;
	tcr_cu_s st_d;

	always_comb begin
		st_d = st_q;
		if (match || force_hit) begin
			unique case (compare_output_mode)
				TCR_COM_OFF: st_d.wave = st_q.wave;
				TCR_COM_TOGGLE: st_d.wave = ~st_q.wave;
				TCR_COM_CLEAR: st_d.wave = 1'b0;
				TCR_COM_SET: st_d.wave = 1'b1;
			endcase
		end else if (wrap && pwm_mode) begin
			// Opposite level restored at bottom in PWM
			if (compare_output_mode == TCR_COM_CLEAR)
				st_d.wave = 1'b1;
			else if (compare_output_mode == TCR_COM_SET)
				st_d.wave = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			st_q <= '0;
		else if (clk_en)
			st_q <= st_d;
	end

	assign wave_out = st_q.wave;
endmodule
`default_nettype wire

// *** tcr_timer_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Force strobes act only in non-PWM modes
// - Force strobe changes pin per compare mode
// - Force sets no flag, no counter clear
// - Force bits always read back zero
// - Counter high byte through shared latch
// - Counter write blocks next-tick compare matches
// - Compare registers continuously matched against counter
// - Compare writes commit both bytes together
// - Capture event loads counter into capture
// - Capture reads coherent through shared latch
// - Request needs enable, global flag, status
// - Capture flag on event or top
// - Compare flags set cycle after match
// - Overflow flag at mode-dependent point
// - Flags cleared by vector or one-write
module tcr_timer_regs
	import tcr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// I/O bus
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [7:0] io_rdata,
	// Timer configuration and timing
	input wire logic timer_tick,
	input wire logic [3:0] waveform_mode_sel,
	input wire logic [1:0] compare_output_mode_a,
	input wire logic [1:0] compare_output_mode_b,
	input wire logic capture_edge_rising,
	input wire logic capture_from_comparator,
	// Pins and comparator
	input wire logic capture_input_pin,
	input wire logic comparator_out,
	output logic wave_out_a,
	output logic wave_out_b,
	// Interrupts
	input wire logic global_irq_en,
	input wire logic [3:0] irq_ack,
	output logic [3:0] irq_req
);
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] ocra;
		logic [15:0] ocrb;
		logic [15:0] icr;
		logic [7:0] temp;
		logic [3:0] mask;
		logic [3:0] flags;
		logic block;
		logic pin_s1;
		logic pin_s2;
		logic cmp_s1;
		logic cmp_s2;
		logic src_prev;
		logic [7:0] rdata;
		logic [3:0] irq;
	} tcr_st_s;

	tcr_st_s st_q;
	tcr_st_s st_d;

	function automatic logic [7:0] ev_to_reg(input logic [3:0] ev);
		logic [7:0] r;
		r = TCR_RST8;
		r[TCR_BIT_CAP] = ev[TCR_EV_CAP];
		r[TCR_BIT_CMPB] = ev[TCR_EV_CMPB];
		r[TCR_BIT_CMPA] = ev[TCR_EV_CMPA];
		r[TCR_BIT_OVF] = ev[TCR_EV_OVF];
		return r;
	endfunction

	function automatic logic [3:0] reg_to_ev(input logic [7:0] r);
		logic [3:0] ev;
		ev = TCR_RST4;
		ev[TCR_EV_CAP] = r[TCR_BIT_CAP];
		ev[TCR_EV_CMPB] = r[TCR_BIT_CMPB];
		ev[TCR_EV_CMPA] = r[TCR_BIT_CMPA];
		ev[TCR_EV_OVF] = r[TCR_BIT_OVF];
		return ev;
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] i);
		logic [15:0] t;
		t = TCR_MAX;
		unique case (m)
			4'h1, 4'h5: t = TCR_TOP8;
			4'h2, 4'h6: t = TCR_TOP9;
			4'h3, 4'h7: t = TCR_TOP10;
			4'h4, 4'h9, 4'hb, 4'hf: t = a;
			4'h8, 4'ha, 4'hc, 4'he: t = i;
			4'h0, 4'hd: t = TCR_MAX;
		endcase
		return t;
	endfunction

	logic [15:0] top;
	logic pwm;
	logic icr_top;
	logic fast_pwm;
	logic at_top;
	logic wrap;
	logic match_a;
	logic match_b;
	logic force_a;
	logic force_b;
	logic cap_src;
	logic cap_edge;
	logic ovf_ev;
	logic [3:0] set_ev;
	logic [3:0] clr_ev;
	logic wr;
	logic rd;

	assign wr = io_we && clk_en;
	assign rd = io_re && clk_en;
	assign top = top_of(waveform_mode_sel, st_q.ocra, st_q.icr);
	assign pwm = !(waveform_mode_sel == 4'h0 || waveform_mode_sel == 4'h4 || waveform_mode_sel == 4'hc
		|| waveform_mode_sel == 4'hd);
	assign fast_pwm = (waveform_mode_sel[2:0] == 3'h5 || waveform_mode_sel[2:0] == 3'h6
		|| waveform_mode_sel == 4'h7 || waveform_mode_sel == 4'he || waveform_mode_sel == 4'hf);
	assign icr_top = (waveform_mode_sel == 4'h8 || waveform_mode_sel == 4'ha || waveform_mode_sel == 4'hc
		|| waveform_mode_sel == 4'he);
	assign at_top = timer_tick && (st_q.cnt == top);
	assign wrap = at_top;
	// Continuous compare, suppressed on the tick after a counter write
	assign match_a = timer_tick && !st_q.block && (st_q.cnt == st_q.ocra);
	assign match_b = timer_tick && !st_q.block && (st_q.cnt == st_q.ocrb);
	// Strobes only reach the waveform units outside PWM
	assign force_a = wr && io_addr == TCR_ADDR_FORCE && io_wdata[TCR_BIT_FORCE_A] && !pwm;
	assign force_b = wr && io_addr == TCR_ADDR_FORCE && io_wdata[TCR_BIT_FORCE_B] && !pwm;
	assign cap_src = capture_from_comparator ? st_q.cmp_s2 : st_q.pin_s2;
	assign cap_edge = !icr_top && (capture_edge_rising ? (cap_src && !st_q.src_prev) : (!cap_src && st_q.src_prev));
	// Overflow point per waveform mode
	assign ovf_ev = timer_tick && (pwm ? (fast_pwm ? (st_q.cnt == top) : wrap) : (st_q.cnt == TCR_MAX));

	always_comb begin
		set_ev = TCR_RST4;
		set_ev[TCR_EV_OVF] = ovf_ev;
		set_ev[TCR_EV_CMPA] = match_a;
		set_ev[TCR_EV_CMPB] = match_b;
		set_ev[TCR_EV_CAP] = icr_top ? at_top : cap_edge;
		clr_ev = irq_ack;
		if (wr && io_addr == TCR_ADDR_FLAGS)
			clr_ev = clr_ev | reg_to_ev(io_wdata);
	end

	always_comb begin
		st_d = st_q;
		st_d.pin_s1 = capture_input_pin;
		st_d.pin_s2 = st_q.pin_s1;
		st_d.cmp_s1 = comparator_out;
		st_d.cmp_s2 = st_q.cmp_s1;
		st_d.src_prev = cap_src;
		// New events win over a clear in the same cycle
		st_d.flags = (st_q.flags & ~clr_ev) | set_ev;
		st_d.irq = st_d.flags & st_q.mask & {4{global_irq_en}};
		if (timer_tick)
			st_d.block = 1'b0;
		if (timer_tick)
			st_d.cnt = at_top ? TCR_RST16 : st_q.cnt + 16'h0001;
		if (cap_edge)
			st_d.icr = st_q.cnt;
		st_d.rdata = TCR_RST8;
		if (wr) begin
			unique case (io_addr)
				TCR_ADDR_CAP_H, TCR_ADDR_CMPA_H, TCR_ADDR_CMPB_H, TCR_ADDR_CNT_H: st_d.temp = io_wdata;
				TCR_ADDR_CNT_L: begin
					st_d.cnt = {st_q.temp, io_wdata};
					st_d.block = 1'b1;
				end
				TCR_ADDR_CMPA_L: st_d.ocra = {st_q.temp, io_wdata};
				TCR_ADDR_CMPB_L: st_d.ocrb = {st_q.temp, io_wdata};
				TCR_ADDR_CAP_L: st_d.icr = {st_q.temp, io_wdata};
				TCR_ADDR_MASK: st_d.mask = reg_to_ev(io_wdata);
				default: st_d.temp = st_q.temp;
			endcase
		end else if (rd) begin
			unique case (io_addr)
				TCR_ADDR_CNT_L: begin
					st_d.rdata = st_q.cnt[7:0];
					st_d.temp = st_q.cnt[15:8];
				end
				TCR_ADDR_CAP_L: begin
					st_d.rdata = st_q.icr[7:0];
					st_d.temp = st_q.icr[15:8];
				end
				TCR_ADDR_CMPA_L: begin
					st_d.rdata = st_q.ocra[7:0];
					st_d.temp = st_q.ocra[15:8];
				end
				TCR_ADDR_CMPB_L: begin
					st_d.rdata = st_q.ocrb[7:0];
					st_d.temp = st_q.ocrb[15:8];
				end
				TCR_ADDR_CNT_H, TCR_ADDR_CAP_H, TCR_ADDR_CMPA_H, TCR_ADDR_CMPB_H: st_d.rdata = st_q.temp;
				TCR_ADDR_FLAGS: st_d.rdata = ev_to_reg(st_q.flags);
				TCR_ADDR_MASK: st_d.rdata = ev_to_reg(st_q.mask);
				TCR_ADDR_FORCE: st_d.rdata = TCR_RST8;
				default: st_d.rdata = TCR_RST8;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			st_q <= '0;
		else if (clk_en)
			st_q <= st_d;
	end

	// Waveform units; forced hits bypass flags and counter clear
	tcr_compare_unit u_cmp_a (
		.clock(clock),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.match(match_a),
		.force_hit(force_a),
		.wrap(wrap),
		.pwm_mode(pwm),
		.compare_output_mode(compare_output_mode_a),
		.wave_out(wave_out_a)
	);

	tcr_compare_unit u_cmp_b (
		.clock(clock),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.match(match_b),
		.force_hit(force_b),
		.wrap(wrap),
		.pwm_mode(pwm),
		.compare_output_mode(compare_output_mode_b),
		.wave_out(wave_out_b)
	);

	assign io_rdata = st_q.rdata;
	assign irq_req = st_q.irq;

	// Checks
	property p_force_pwm;
		@(posedge clock) disable iff (!rst_b)
			(wr && io_addr == TCR_ADDR_FORCE && pwm && !timer_tick) |=> $stable(wave_out_a) && $stable(wave_out_b);
	endproperty
	a_force_pwm: assert property (p_force_pwm) else $error("force acted in PWM");

	property p_force_set;
		@(posedge clock) disable iff (!rst_b) (force_b && compare_output_mode_b == TCR_COM_SET) |=> wave_out_b;
	endproperty
	a_force_set: assert property (p_force_set) else $error("forced set missing");

	property p_force_noflag;
		@(posedge clock) disable iff (!rst_b)
			(force_a && !match_a && !st_q.flags[TCR_EV_CMPA]) |=> !st_q.flags[TCR_EV_CMPA];
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("force set flag");

	property p_force_read;
		@(posedge clock) disable iff (!rst_b) (rd && !io_we && io_addr == TCR_ADDR_FORCE) |=> io_rdata == TCR_RST8;
	endproperty
	a_force_read: assert property (p_force_read) else $error("force bits read nonzero");

	property p_cnt_latch;
		@(posedge clock) disable iff (!rst_b)
			(rd && !io_we && io_addr == TCR_ADDR_CNT_L) |=> st_q.temp == $past(st_q.cnt[15:8]);
	endproperty
	a_cnt_latch: assert property (p_cnt_latch) else $error("counter high byte not latched");

	property p_block;
		@(posedge clock) disable iff (!rst_b)
			(clk_en && timer_tick && st_q.block && st_q.cnt == st_q.ocra && !st_q.flags[TCR_EV_CMPA])
				|=> !st_q.flags[TCR_EV_CMPA];
	endproperty
	a_block: assert property (p_block) else $error("match after counter write");

	property p_cmp_write;
		@(posedge clock) disable iff (!rst_b)
			(wr && io_addr == TCR_ADDR_CMPA_L) |=> st_q.ocra == {$past(st_q.temp), $past(io_wdata)};
	endproperty
	a_cmp_write: assert property (p_cmp_write) else $error("compare A not committed");

	property p_irq;
		@(posedge clock) disable iff (!rst_b)
			clk_en ##1 clk_en |-> irq_req[TCR_EV_CAP] == ($past(st_d.flags[TCR_EV_CAP]) && $past(st_q.mask[TCR_EV_CAP])
				&& $past(global_irq_en));
	endproperty
	a_irq: assert property (p_irq) else $error("capture request mismatch");

	property p_match_flag;
		@(posedge clock) disable iff (!rst_b) (match_a && clk_en) |=> st_q.flags[TCR_EV_CMPA];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("compare A flag not set");

	property p_ack_clear;
		@(posedge clock) disable iff (!rst_b) (clk_en && irq_ack[TCR_EV_CMPA] && !match_a) |=> !st_q.flags[TCR_EV_CMPA];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("compare A flag not cleared");

	property p_reset;
		@(posedge clock) !rst_b |=> st_q.flags == TCR_RST4 && st_q.cnt == TCR_RST16 && io_rdata == TCR_RST8;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state not zero");

	property p_cov_cap;
		@(posedge clock) disable iff (!rst_b) cap_edge && clk_en;
	endproperty
	c_cov_cap: cover property (p_cov_cap);

	property p_cov_match;
		@(posedge clock) disable iff (!rst_b) match_a && clk_en ##1 irq_req[TCR_EV_CMPA];
	endproperty
	c_cov_match: cover property (p_cov_match);

	property p_cov_force;
		@(posedge clock) disable iff (!rst_b) force_b;
	endproperty
	c_cov_force: cover property (p_cov_force);
endmodule
`default_nettype wire

// *** tcr_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcr_cpu_model (
	// Clock
	input wire logic clock,
	// I/O bus
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata
);
	initial begin
		io_addr = 6'h00;
		io_wdata = 8'h00;
		io_we = 1'b0;
		io_re = 1'b0;
	end
	// One access, dropped at the next falling edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_wdata = d;
		io_we = 1'b1;
		@(negedge clock);
		io_we = 1'b0;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_re = 1'b1;
		@(negedge clock);
		io_re = 1'b0;
		d = io_rdata;
	endtask
	// High byte first, low byte commits
	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr(a + 6'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask
	// Low byte first, latches high byte
	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 6'h01, v[15:8]);
	endtask
endmodule
`default_nettype wire

// *** test_tcr_timer_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_tcr_timer_regs;
	import tcr_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic timer_tick = 1'b0;
	logic [3:0] waveform_mode_sel = 4'h0;
	logic [1:0] com_a = 2'h0;
	logic [1:0] com_b = 2'h0;
	logic cap_sel = 1'b0;
	logic cap_pin = 1'b0;
	logic comp_out = 1'b0;
	logic global_irq_en = 1'b0;
	logic [3:0] irq_ack = 4'h0;
	logic [3:0] irq_req;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic io_we;
	logic io_re;
	logic wave_out_a;
	logic wave_out_b;
	int n_fail = 0;
	int n_checks = 0;
	always #25 clock = ~clock;
	tcr_cpu_model cpu_u (.clock(clock), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
		.io_rdata(io_rdata));
	tcr_timer_regs dut_u (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .timer_tick(timer_tick),
		.waveform_mode_sel(waveform_mode_sel), .compare_output_mode_a(com_a), .compare_output_mode_b(com_b),
		.capture_edge_rising(1'b1), .capture_from_comparator(cap_sel), .capture_input_pin(cap_pin),
		.comparator_out(comp_out), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req));
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [15:0] exp, input string name);
		logic [7:0] d;
		cpu_u.rd(a, d);
		chk(name, exp, {8'h00, d});
	endtask
	task automatic rdc16(input logic [5:0] a, input logic [15:0] exp, input string name);
		logic [15:0] v;
		cpu_u.rd16(a, v);
		chk(name, exp, v);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge clock);
			timer_tick = 1'b1;
			@(negedge clock);
			timer_tick = 1'b0;
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Hang guard, far above the fewer than two hundred cycles used
	initial begin
		#(50 * 6000);
		n_fail++;
		conclude();
	end
	initial begin
		wait_n(5);
		rst_b = 1'b1;
		rdc(TCR_ADDR_FLAGS, 16'h0000, "flags");
		rdc(TCR_ADDR_MASK, 16'h0000, "mask");
		rdc16(TCR_ADDR_CAP_L, 16'h0000, "capture");
		cpu_u.wr(TCR_ADDR_MASK, 8'h27);
		rdc(TCR_ADDR_MASK, 16'h0027, "mask");
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h1234);
		rdc16(TCR_ADDR_CNT_L, 16'h1234, "counter");
		$display("Test registers done");
		cpu_u.wr16(TCR_ADDR_CMPA_L, 16'h0005);
		cpu_u.wr16(TCR_ADDR_CMPB_L, 16'h0006);
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h0005);
		tick(1);
		rdc(TCR_ADDR_FLAGS, 16'h0000, "blocked");
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h0003);
		tick(3);
		rdc(TCR_ADDR_FLAGS, 16'h0002, "match a");
		tick(1);
		rdc(TCR_ADDR_FLAGS, 16'h0006, "match b");
		$display("Test compare done");
		global_irq_en = 1'b1;
		wait_n(3);
		chk("irq on", 16'h0006, {12'h000, irq_req});
		global_irq_en = 1'b0;
		wait_n(3);
		chk("irq off", 16'h0000, {12'h000, irq_req});
		global_irq_en = 1'b1;
		cpu_u.wr(TCR_ADDR_FLAGS, 8'h00);
		rdc(TCR_ADDR_FLAGS, 16'h0006, "zero write");
		@(negedge clock);
		irq_ack = 4'h2;
		@(negedge clock);
		irq_ack = 4'h0;
		rdc(TCR_ADDR_FLAGS, 16'h0004, "ack");
		cpu_u.wr(TCR_ADDR_FLAGS, 8'h04);
		rdc(TCR_ADDR_FLAGS, 16'h0000, "one write");
		$display("Test interrupts done");
		waveform_mode_sel = 4'h4;
		com_a = TCR_COM_TOGGLE;
		com_b = TCR_COM_SET;
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h0010);
		cpu_u.wr(TCR_ADDR_FORCE, 8'hc0);
		wait_n(2);
		chk("forced pins", 16'h0003, {14'h0000, wave_out_a, wave_out_b});
		rdc(TCR_ADDR_FORCE, 16'h0000, "force read");
		rdc(TCR_ADDR_FLAGS, 16'h0000, "force flags");
		rdc16(TCR_ADDR_CNT_L, 16'h0010, "force ctc");
		waveform_mode_sel = 4'h5;
		cpu_u.wr(TCR_ADDR_FORCE, 8'hc0);
		wait_n(2);
		chk("pwm force", 16'h0003, {14'h0000, wave_out_a, wave_out_b});
		cpu_u.wr(TCR_ADDR_FORCE, 8'h00);
		waveform_mode_sel = 4'h0;
		$display("Test force done");
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h0102);
		cap_pin = 1'b1;
		wait_n(6);
		rdc16(TCR_ADDR_CAP_L, 16'h0102, "capture pin");
		rdc(TCR_ADDR_FLAGS, 16'h0020, "capture flag");
		cpu_u.wr(TCR_ADDR_FLAGS, 8'h20);
		cap_sel = 1'b1;
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h0a0b);
		comp_out = 1'b1;
		wait_n(6);
		rdc16(TCR_ADDR_CAP_L, 16'h0a0b, "capture comp");
		cpu_u.wr(TCR_ADDR_FLAGS, 8'h20);
		$display("Test capture done");
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'hfffe);
		tick(2);
		rdc(TCR_ADDR_FLAGS, 16'h0001, "overflow");
		wait_n(2);
		chk("irq ovf", 16'h0001, {12'h000, irq_req});
		$display("Test overflow done");
		cpu_u.wr(TCR_ADDR_FLAGS, 8'h01);
		waveform_mode_sel = 4'h5;
		com_a = TCR_COM_CLEAR;
		cpu_u.wr16(TCR_ADDR_CNT_L, 16'h00fe);
		tick(2);
		rdc(TCR_ADDR_FLAGS, 16'h0001, "pwm top");
		chk("pwm bottom", 16'h0002, {14'h0000, wave_out_a, wave_out_b});
		tick(7);
		chk("pwm match", 16'h0001, {14'h0000, wave_out_a, wave_out_b});
		rdc(TCR_ADDR_FLAGS, 16'h0007, "pwm flags");
		$display("Test pwm done");
		conclude();
	end
endmodule
`default_nettype wire
